/* File: design/audio_rx_params.svh */
// Offsets, field positions, reset values and timing counts of the serial audio input port.
// Behaviour
// - Three wires: bit clock, word clock, data
// - Internal clocks derived from bit clock only
// - Detect 32k, 44.1-48k, 88.2-96k rate groups
// - Clock stop: sleep, outputs Hi-Z, resume
// - Accept listed word lengths and clock ratios
// - Status shows halt or bad clock ratio
// - Halt forces Hi-Z, recovery restores play
// - Format field selects I2S, LJ, RJ, TDM
// - MSB first two's complement, up to 32 bits
// - Low format bits select word length
// - Nine-bit data start offset over two registers
// - Reset default is I2S, 24-bit words
// - TDM frame starts on frame sync rising edge
// - I2S: word clock low left, high right
// - RJ: word clock high left, low right
`ifndef AUDIO_RX_PARAMS_SVH
`define AUDIO_RX_PARAMS_SVH

`define FMT_ADDR 8'h33
`define OFS_ADDR 8'h34
`define STAT_ADDR 8'h71
`define FMT_RESET 8'h02
`define OFS_RESET 8'h00
`define FMT_OFS_MSB 7
`define FMT_SEL_HI 5
`define FMT_SEL_LO 4
`define FMT_SHORT_HI 3
`define FMT_SHORT_LO 2
`define FMT_WL_HI 1
`define FMT_WL_LO 0
`define STAT_CLK_ERR 0
`define STAT_HALT 1
`define STAT_RATIO 2
`define STAT_LOCK 3
`define STAT_RATE_LO 4
`define STAT_RATE_HI 5

`define SYS_CLK_MHZ 100
`define BCLK_HALT_NS 2000
`define BCLK_HALT_CYC ((`BCLK_HALT_NS * `SYS_CLK_MHZ) / 1000)
`define FRAME_HALT_NS 40000
`define FRAME_HALT_CYC ((`FRAME_HALT_NS * `SYS_CLK_MHZ) / 1000)
`define RATE_32K_MIN 16'h0A8C
`define RATE_48K_MIN 16'h0640
`define LOCK_FRAMES 4
`define TDM_SLOT_BITS 11'h020

`endif

/* File: design/audio_rx_pkg.sv */
// Types shared by the serial audio input port.
package audio_rx_pkg;
    typedef enum logic [1:0] {FMT_I2S, FMT_LJ, FMT_RJ, FMT_TDM} fmt_t;
    typedef enum logic [1:0] {RATE_32K, RATE_48K, RATE_96K, RATE_NONE} rate_t;
    typedef enum {ST_HALT, ST_LOCKING, ST_PLAY} rx_state_t;
    typedef struct packed {
        logic right;
        logic [31:0] data;
    } sample_t;
endpackage

/* File: design/serial_audio_input_port.sv */
// Serial audio receiver with rate detection, clock-halt handling and a control register file.
`timescale 1ns/1ps
`include "audio_rx_params.svh"
module serial_audio_input_port
    import audio_rx_pkg::*;
#(
    parameter int BCLK_HALT_CYC = `BCLK_HALT_CYC,
    parameter int FRAME_HALT_CYC = `FRAME_HALT_CYC,
    parameter int LOCK_FRAMES = `LOCK_FRAMES
) (
    input wire logic sys_clk, // System clock, 100 MHz
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic clk_en, // Freezes all state while low
    input wire logic bit_clk, // Serial bit clock pin
    input wire logic word_clock_frame_sync, // Word clock or TDM frame sync pin
    input wire logic serial_data_in, // Serial data pin
    input wire logic [7:0] reg_addr, // Control port register address
    input wire logic reg_wr, // Control port write strobe
    input wire logic reg_rd, // Control port read strobe
    input wire logic [7:0] reg_wdata, // Control port write data
    output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
    output sample_t sample, // Received sample and its channel
    output logic sample_valid, // One-cycle pulse per sample received during play
    output logic pll_locked, // Derived clocks running
    output rate_t rate, // Detected sample rate group
    output logic dsp_sleep, // Processor held in sleep
    output logic out_hiz, // Amplifier outputs forced to Hi-Z
    output logic clk_err // Clock halt or unsupported ratio
);
    logic bclk_s1_q;
    logic bclk_s2_q;
    logic bclk_s3_q;
    logic ws_s1_q;
    logic ws_s2_q;
    logic ws_prev_q;
    logic sd_s1_q;
    logic sd_s2_q;
    logic [7:0] fmt_q;
    logic [7:0] ofs_q;
    logic [7:0] rdata_q;
    logic [9:0] cnt_q;
    logic [10:0] half_len_q;
    logic [10:0] frame_bits_q;
    logic [10:0] frame_len_q;
    logic [15:0] bclk_idle_q;
    logic [15:0] frame_idle_q;
    logic [15:0] period_q;
    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic [3:0] good_q;
    logic ratio_err_q;
    rate_t rate_q;
    rx_state_t state_q;
    rx_state_t state_d;
    sample_t sample_q;
    logic sample_valid_q;

    // Every pin passes two flip-flops before use; the third bit clock stage finds edges.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bclk_s1_q <= 1'b0;
            bclk_s2_q <= 1'b0;
            bclk_s3_q <= 1'b0;
        end else if (clk_en) begin
            bclk_s1_q <= bit_clk;
            bclk_s2_q <= bclk_s1_q;
            bclk_s3_q <= bclk_s2_q;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ws_s1_q <= 1'b0;
            ws_s2_q <= 1'b0;
        end else if (clk_en) begin
            ws_s1_q <= word_clock_frame_sync;
            ws_s2_q <= ws_s1_q;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sd_s1_q <= 1'b0;
            sd_s2_q <= 1'b0;
        end else if (clk_en) begin
            sd_s1_q <= serial_data_in;
            sd_s2_q <= sd_s1_q;
        end
    end

    fmt_t fmt;
    logic [1:0] wl_code;
    logic [10:0] wl_bits;
    logic [10:0] offset;
    logic bclk_rise;
    logic ws_changed;
    logic frame_start;
    logic half_start;
    logic [10:0] pos;
    logic tdm_right;
    logic [10:0] rj_base;
    logic [10:0] start;
    logic in_win;
    logic [10:0] idx;
    logic last_bit;
    logic ch_right;

    assign fmt = fmt_t'(fmt_q[`FMT_SEL_HI:`FMT_SEL_LO]);
    assign wl_code = fmt_q[`FMT_WL_HI:`FMT_WL_LO];
    assign wl_bits = (wl_code == 2'h0) ? 11'h010 :
                     (wl_code == 2'h1) ? 11'h014 :
                     (wl_code == 2'h2) ? 11'h018 : 11'h020;
    assign offset = {2'h0, fmt_q[`FMT_OFS_MSB], ofs_q};
    // Data is shifted in on the bit clock rising edge.
    assign bclk_rise = bclk_s2_q & ~bclk_s3_q;
    assign ws_changed = bclk_rise & (ws_s2_q != ws_prev_q);
    // I2S frames open with the left half (word clock low); others on a rising edge.
    assign frame_start = bclk_rise & ((fmt == FMT_I2S) ? (~ws_s2_q & ws_prev_q)
                                                       : (ws_s2_q & ~ws_prev_q));
    assign half_start = (fmt == FMT_TDM) ? frame_start : ws_changed;
    assign pos = half_start ? 11'h000 : {1'b0, cnt_q} + 11'h001;
    assign tdm_right = (fmt == FMT_TDM) && (pos >= offset + `TDM_SLOT_BITS);
    assign rj_base = (half_len_q > wl_bits) ? half_len_q - wl_bits : 11'h000;
    assign start = offset + ((fmt == FMT_I2S) ? 11'h001 : 11'h000) +
                   ((fmt == FMT_RJ) ? rj_base : 11'h000) +
                   (tdm_right ? `TDM_SLOT_BITS : 11'h000);
    assign in_win = bclk_rise && (pos >= start) && (pos < start + wl_bits);
    assign idx = pos - start;
    assign last_bit = in_win && (idx == wl_bits - 11'h001);
    assign ch_right = (fmt == FMT_TDM) ? tdm_right :
                      (fmt == FMT_I2S) ? ws_s2_q : ~ws_s2_q;

    // Bits fill from the top down, so every word length is MSB-aligned in 32 bits.
    always_comb begin
        acc_d = (idx == 11'h000) ? 32'h0 : acc_q;
        acc_d[5'd31 - idx[4:0]] = sd_s2_q;
    end

    // Bit position in the current half, and the length of the last half for right-justified.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ws_prev_q <= 1'b0;
            cnt_q <= 10'h000;
            half_len_q <= 11'h000;
        end else if (clk_en && bclk_rise) begin
            ws_prev_q <= ws_s2_q;
            if (half_start) begin
                cnt_q <= 10'h000;
                half_len_q <= {1'b0, cnt_q} + 11'h001;
            end else if (cnt_q != 10'h3FF) begin
                cnt_q <= cnt_q + 10'h001;
            end
        end
    end

    // Bit clocks per frame, held against the supported ratios at each frame start.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            frame_bits_q <= 11'h000;
            frame_len_q <= 11'h000;
        end else if (clk_en && bclk_rise) begin
            if (frame_start) begin
                frame_bits_q <= 11'h001;
                frame_len_q <= frame_bits_q;
            end else if (frame_bits_q != 11'h7FF) begin
                frame_bits_q <= frame_bits_q + 11'h001;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            acc_q <= 32'h0;
        end else if (clk_en && in_win) begin
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sample_q <= '0;
            sample_valid_q <= 1'b0;
        end else if (clk_en) begin
            sample_valid_q <= 1'b0;
            if (last_bit) begin
                sample_q <= '{right: ch_right, data: acc_d};
                sample_valid_q <= (state_q == ST_PLAY);
            end
        end
    end

    // Halt watchdogs: no bit clock edge, or no frame start, for too long.
    logic bclk_halt;
    logic frame_halt;
    logic halted;
    logic ratio_ok;
    rate_t rate_meas;

    assign bclk_halt = bclk_idle_q >= 16'(BCLK_HALT_CYC);
    assign frame_halt = frame_idle_q >= 16'(FRAME_HALT_CYC);
    // A host changing rate stops the clocks long enough for this to trip.
    assign halted = bclk_halt | frame_halt;
    assign rate_meas = (frame_idle_q >= `RATE_32K_MIN) ? RATE_32K :
                       (frame_idle_q >= `RATE_48K_MIN) ? RATE_48K : RATE_96K;
    assign ratio_ok = (fmt == FMT_TDM) ?
                      ((frame_bits_q == 11'h080) ||
                       (rate_meas != RATE_32K &&
                        (frame_bits_q == 11'h100 || frame_bits_q == 11'h200))) :
                      ((frame_bits_q == 11'h020 || frame_bits_q == 11'h040) &&
                       rate_meas != RATE_NONE);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bclk_idle_q <= 16'h0;
        end else if (clk_en) begin
            if (bclk_rise) begin
                bclk_idle_q <= 16'h0;
            end else if (bclk_idle_q != 16'hFFFF) begin
                bclk_idle_q <= bclk_idle_q + 16'h1;
            end
        end
    end

    // The frame period in system cycles doubles as the sample rate measurement.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            frame_idle_q <= 16'h0;
            period_q <= 16'h0;
            rate_q <= RATE_NONE;
            ratio_err_q <= 1'b0;
        end else if (clk_en) begin
            if (frame_start) begin
                frame_idle_q <= 16'h0;
                period_q <= frame_idle_q;
                rate_q <= rate_meas;
                ratio_err_q <= ~ratio_ok;
            end else if (frame_idle_q != 16'hFFFF) begin
                frame_idle_q <= frame_idle_q + 16'h1;
            end
        end
    end

    // Derived clocking acquires lock only after several good frames.
    logic good_frame;
    logic lock_done;

    assign good_frame = frame_start & ratio_ok & (rate_meas == rate_q);
    assign lock_done = good_frame && (good_q >= 4'(LOCK_FRAMES - 1));

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_HALT: begin
                if (!halted) begin
                    state_d = ST_LOCKING;
                end
            end
            ST_LOCKING: begin
                if (halted) begin
                    state_d = ST_HALT;
                end else if (lock_done) begin
                    state_d = ST_PLAY;
                end
            end
            ST_PLAY: begin
                if (halted) begin
                    state_d = ST_HALT;
                end else if (frame_start && !good_frame) begin
                    state_d = ST_LOCKING;
                end
            end
            default: begin
                state_d = ST_HALT;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_HALT;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // Good frames count only while locking, and any bad frame starts the count again.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            good_q <= 4'h0;
        end else if (clk_en) begin
            if (state_q != ST_LOCKING || (frame_start && !good_frame)) begin
                good_q <= 4'h0;
            end else if (good_frame && good_q != 4'hF) begin
                good_q <= good_q + 4'h1;
            end
        end
    end

    // Control register file.
    logic [7:0] status;
    logic wr_fmt;
    logic wr_ofs;
    logic [7:0] rd_mux;

    assign status = {2'h0, rate_q, (state_q == ST_PLAY), ratio_err_q, halted,
                     halted | ratio_err_q};
    assign wr_fmt = reg_wr && (reg_addr == `FMT_ADDR);
    assign wr_ofs = reg_wr && (reg_addr == `OFS_ADDR);
    // Unmapped addresses read as zero; the status register ignores writes.
    assign rd_mux = (reg_addr == `FMT_ADDR) ? fmt_q :
                    (reg_addr == `OFS_ADDR) ? ofs_q :
                    (reg_addr == `STAT_ADDR) ? status : 8'h00;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fmt_q <= `FMT_RESET;
        end else if (clk_en && wr_fmt) begin
            fmt_q <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ofs_q <= `OFS_RESET;
        end else if (clk_en && wr_ofs) begin
            ofs_q <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (clk_en && reg_rd) begin
            rdata_q <= rd_mux;
        end
    end

    assign reg_rdata = rdata_q;
    assign sample = sample_q;
    assign sample_valid = sample_valid_q;
    assign pll_locked = (state_q == ST_PLAY);
    assign rate = rate_q;
    assign dsp_sleep = (state_q == ST_HALT);
    assign out_hiz = (state_q != ST_PLAY);
    assign clk_err = status[`STAT_CLK_ERR];
endmodule

/* File: test/audio_host_model.sv */
// Behavioural audio source driving the three-wire serial link.
`timescale 1ns/1ps
module audio_host_model (
    input logic run, // Send frames while high
    input logic lj, // Left-justified instead of I2S
    input logic rj, // Right-justified instead of I2S
    input logic [23:0] l_word, // Left sample
    input logic [23:0] r_word, // Right sample
    output logic bit_clk, // Bit clock, still between bursts
    output logic ws, // Word clock
    output logic sd // Serial data
);
    int h, i, j;
    logic [23:0] w;
    initial begin
        bit_clk = 0;
        ws = 1;
        sd = 0;
        forever begin
            wait (run);
            for (h = 0; h < 2; h++) begin
                w = h ? r_word : l_word;
                for (i = 0; i < 32; i++) begin
                    j = rj ? i - 8 : (lj ? i : i - 1);
                    ws = 1'(h) ^ (lj | rj);
                    sd = (j >= 0 && j < 24) ? w[23 - j] : 1'($urandom);
                    #62.5 bit_clk = 1;
                    #62.5 bit_clk = 0;
                end
            end
            if (!run) sd = ~sd;
        end
    end
endmodule

/* File: test/serial_audio_input_port_assertions.sv */
// Checker of the serial audio input port outputs.
`timescale 1ns/1ps
module audio_rx_checker
    import audio_rx_pkg::*;
(
    input logic sys_clk, // Clock
    input logic nrst, // Reset
    input logic clk_en, // Enable
    input logic [7:0] reg_addr, // Address
    input logic reg_rd, // Read strobe
    input logic [7:0] reg_rdata, // Read data
    input sample_t sample, // Sample
    input logic sample_valid, // Sample strobe
    input logic pll_locked, // Locked
    input rate_t rate, // Rate group
    input logic dsp_sleep, // Sleep
    input logic out_hiz, // Hi-Z
    input logic clk_err // Clock error
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire rd_ok = reg_rd && clk_en;
    wire mapped = reg_addr inside {8'h33, 8'h34, 8'h71};
    hiz_unlocked_a: assert property (out_hiz == !pll_locked)
        else $error("hiz and lock disagree");
    sleep_hiz_a: assert property (dsp_sleep |-> out_hiz && !pll_locked)
        else $error("sleep without hiz");
    valid_play_a: assert property (sample_valid |-> pll_locked)
        else $error("sample outside play");
    valid_pulse_a: assert property (sample_valid |=> !sample_valid)
        else $error("sample strobe too long");
    locked_rate_a: assert property (pll_locked |-> rate != RATE_NONE)
        else $error("locked without rate");
    status_read_a: assert property (rd_ok && reg_addr == 8'h71 |=>
        reg_rdata[0] == $past(clk_err) && reg_rdata[3] == $past(pll_locked)
        && reg_rdata[5:4] == $past(rate)) else $error("status read wrong");
    unmapped_zero_a: assert property (rd_ok && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!rd_ok |=> $stable(reg_rdata))
        else $error("read data moved");
    cover property (sample_valid && sample.right);
    cover property ($rose(pll_locked));
    cover property ($rose(dsp_sleep));
endmodule
bind serial_audio_input_port audio_rx_checker u_chk (.sys_clk, .nrst, .clk_en, .reg_addr,
    .reg_rd, .reg_rdata, .sample, .sample_valid, .pll_locked, .rate, .dsp_sleep, .out_hiz,
    .clk_err);

/* File: test/serial_audio_input_port_tb.sv */
// Self-checking bench of the serial audio input port.
`timescale 1ns/1ps
module serial_audio_input_port_tb;
    import audio_rx_pkg::*;
    logic sys_clk = 0, nrst = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, run = 0, lj = 0, rj = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
    logic [23:0] lw = 24'h000000, rw = 24'h000000;
    logic bclk, ws, sd, sample_valid, pll_locked, dsp_sleep, out_hiz, clk_err;
    sample_t sample;
    rate_t rate;
    int fail_count = 0, n_tests = 0, cyc = 0, i;
    serial_audio_input_port #(.LOCK_FRAMES(2)) u_dut (.sys_clk, .nrst, .clk_en, .bit_clk(bclk),
        .word_clock_frame_sync(ws), .serial_data_in(sd), .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .sample, .sample_valid, .pll_locked, .rate, .dsp_sleep,
        .out_hiz, .clk_err);
    audio_host_model u_host (.run, .lj, .rj, .l_word(lw), .r_word(rw), .bit_clk(bclk), .ws,
        .sd);
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(posedge sys_clk);
        #1 reg_addr = a;
        reg_wdata = v;
        reg_wr = 1;
        @(posedge sys_clk);
        #1 reg_wr = 0;
    endtask
    task automatic rd_chk(input logic [7:0] a, v);
        @(posedge sys_clk);
        #1 reg_addr = a;
        reg_rd = 1;
        @(posedge sys_clk);
        #1 reg_rd = 0;
        chk(reg_rdata, v);
    endtask
    // Waits for sleep or lock, then checks all mode outputs together.
    task automatic wait_state(input logic sleep);
        int t;
        for (t = 0; t < 8000 && (sleep ? dsp_sleep : pll_locked) !== 1'b1; t++) begin
            @(posedge sys_clk);
            #1;
        end
        chk({dsp_sleep, out_hiz, pll_locked, clk_err}, sleep ? 4'b1101 : 4'b0010);
    endtask
    task automatic samples(input int n);
        logic prev;
        int k, t;
        prev = 1'b1;
        for (k = 0; k < n; k++) begin
            t = 0;
            do begin
                @(posedge sys_clk);
                #1;
                t++;
            end while (sample_valid !== 1'b1 && t < 2000);
            chk(sample_valid, 1'b1);
            chk(sample.data, sample.right ? {rw, 8'h00} : {lw, 8'h00});
            if (k > 0) chk(sample.right, !prev);
            prev = sample.right;
        end
    endtask
    task automatic conclude();
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        i = $urandom(30);
        repeat (10) @(posedge sys_clk);
        #1 nrst = 1;
        rd_chk(8'h33, 8'h02);
        rd_chk(8'h34, 8'h00);
        rd_chk(8'h50, 8'h00);
        $display("test 1 done");
        for (i = 0; i < 4; i++) begin
            d = {1'($urandom), 1'b0, 2'(i), 2'b01, 2'($urandom)};
            wr(8'h33, d);
            rd_chk(8'h33, d);
        end
        d = 8'($urandom);
        wr(8'h34, d);
        rd_chk(8'h34, d);
        wr(8'h33, 8'h02);
        wr(8'h34, 8'h00);
        $display("test 2 done");
        lw = 24'h800000;
        rw = 24'h7FFFFF;
        run = 1;
        wait_state(0);
        samples(6);
        rd_chk(8'h71, 8'({RATE_96K, 4'h8}));
        $display("test 3 done");
        run = 0;
        wait_state(1);
        $display("test 4 done");
        wr(8'h33, 8'h12);
        lj = 1;
        lw = 24'($urandom);
        rw = 24'($urandom);
        run = 1;
        wait_state(0);
        samples(6);
        rd_chk(8'h33, 8'h12);
        $display("test 5 done");
        run = 0;
        wait_state(1);
        wr(8'h33, 8'h22);
        lj = 0;
        rj = 1;
        lw = 24'($urandom);
        rw = 24'($urandom);
        run = 1;
        wait_state(0);
        samples(6);
        rd_chk(8'h33, 8'h22);
        $display("test 6 done");
        conclude();
    end
endmodule
